// file: hw/ezl_device.sv
// zone-lock logic of the serial eeprom: lock read, lock set, freeze, write guard
// assumes the host end keeps the link rules; nv cells sit outside and are
// preloaded through nv_*_init, which are sampled once after reset release
//
// What this block does
// - four independent 256-bit zones, any combination lockable
// - zones 0-3 map to lock addresses 1,2,4,8
// - lock 0 writable, lock 1 permanently read-only
// - lock bits live in nonvolatile storage
// - lock bit only goes 0 to 1
// - opcode 7 write-direction address byte acked
// - lock address upper nibble ignored, acked
// - repeated-start read returns 00h or FFh
// - set lock: opcode 7, address, FFh acked unless frozen
// - stop after FFh starts write; earlier aborts
// - silent until write cycle time elapses
// - host avoids line low during write cycle; abort command pulls it low
// - freeze opcode acked unless already frozen
// - freeze needs 55h then AAh, else nack
// - stop after AAh freezes; earlier aborts
// - after freeze, lock bits never change
// - host leaves line released during freeze write; abort command pulls it low
// - write into locked zone: data nacked, no write
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module ezl_device #(
  parameter int unsigned WR_CYCLES = ezl_pkg::NV_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  // link
  ezl_link_if.dev         link,
  // strap and nonvolatile cells
  input  wire logic [2:0] client_addr,
  input  wire logic [3:0] nv_lock_init,
  input  wire logic       nv_frozen_init,
  output logic      [3:0] nv_lock,
  output logic            nv_frozen,
  output logic            nv_busy,
  // array write port
  output logic            mem_wr,
  output logic      [6:0] mem_addr,
  output logic      [7:0] mem_data
);

  typedef enum {D_LOAD, D_IDLE, D_CMD, D_ZADDR, D_ZDATA, D_ZARMED, D_ZREAD,
                D_FADDR, D_FDATA, D_FARMED, D_MADDR, D_MDATA, D_BUSY} ezl_dstate_e;

  ezl_dstate_e state_q, state_d;
  logic [3:0]  lock_q;
  logic        frozen_q;
  logic [3:0]  zmask_q;
  logic        zvalid_q;
  logic        frz_pend_q;
  logic [6:0]  maddr_q;
  logic [ezl_pkg::CNT_W-1:0] cnt_q;
  logic        ack_valid_q, ack_q, rd_valid_q;
  logic [7:0]  rd_data_q;
  logic        mem_wr_q;
  logic [7:0]  mem_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // byte decode
  wire [3:0] b_op      = link.byte_data[7:4];
  wire [2:0] b_ca      = link.byte_data[3:1];
  wire       b_rd      = link.byte_data[0];
  wire       ca_hit    = b_ca == client_addr;
  wire [3:0] b_zone    = link.byte_data[3:0];
  wire       zaddr_ok  = b_zone == ezl_pkg::ZONE0_LOCK_ADDR || b_zone == ezl_pkg::ZONE1_LOCK_ADDR
                      || b_zone == ezl_pkg::ZONE2_LOCK_ADDR || b_zone == ezl_pkg::ZONE3_LOCK_ADDR;
  wire       is_zone_w = ca_hit && b_op == ezl_pkg::OP_ZONE && !b_rd;
  wire       is_zone_r = ca_hit && b_op == ezl_pkg::OP_ZONE && b_rd;
  wire       is_frz    = ca_hit && b_op == ezl_pkg::OP_FREEZE && !b_rd;
  wire       is_mem_w  = ca_hit && b_op == ezl_pkg::OP_MEM && !b_rd;
  wire [1:0] mzone     = maddr_q[ezl_pkg::ZONE_SEL_MSB:ezl_pkg::ZONE_SEL_LSB];
  wire       mlocked   = lock_q[mzone];
  wire       zlocked   = |(lock_q & zmask_q);
  wire       cyc_done  = cnt_q == ezl_pkg::CNT_W'(WR_CYCLES - 1);
  wire       busy      = state_q == D_BUSY;
  wire       bv        = link.byte_valid && !busy && state_q != D_LOAD;

  // ack answer for the byte in this cycle, by state
  logic ack_now;
  always_comb
  begin
    ack_now = 1'b0;
    case (state_q)
      D_CMD:   ack_now = is_zone_w || (is_zone_r && zvalid_q) || (is_frz && !frozen_q) || is_mem_w;
      D_ZADDR: ack_now = zaddr_ok;
      D_ZDATA: ack_now = link.byte_data == ezl_pkg::LOCK_SET_BYTE && !frozen_q;
      D_FADDR: ack_now = link.byte_data == ezl_pkg::FRZ_ADDR_BYTE;
      D_FDATA: ack_now = link.byte_data == ezl_pkg::FRZ_DATA_BYTE;
      D_MADDR: ack_now = 1'b1;
      D_MDATA: ack_now = !mlocked;
      default: ack_now = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      D_LOAD:
        state_d = D_IDLE;
      D_BUSY:
        if (cyc_done || link.line_low)
          state_d = D_IDLE;
      default:
        if (link.start)
          state_d = D_CMD;
        else if (link.stop)
          // only an armed sequence survives its stop; all others abort
          state_d = state_q == D_ZARMED || state_q == D_FARMED ? D_BUSY : D_IDLE;
        else if (bv && !ack_now)
          state_d = D_IDLE;
        else if (bv)
        begin
          case (state_q)
            D_CMD:
              if (is_zone_w)
                state_d = D_ZADDR;
              else if (is_zone_r)
                state_d = D_ZREAD;
              else if (is_frz)
                state_d = D_FADDR;
              else
                state_d = D_MADDR;
            D_ZADDR: state_d = D_ZDATA;
            D_ZDATA: state_d = D_ZARMED;
            D_FADDR: state_d = D_FDATA;
            D_FDATA: state_d = D_FARMED;
            D_MADDR: state_d = D_MDATA;
            D_MDATA: state_d = D_IDLE;
            default: state_d = state_q;
          endcase
        end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state and nonvolatile image
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= D_LOAD;
    else if (ce)
      state_q <= state_d;
  end

  // cells are cleared by reset and reloaded from nv in the first cycle after its release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_q   <= 4'h0;
      frozen_q <= 1'b0;
    end
    else if (ce && state_q == D_LOAD)
    begin
      lock_q   <= nv_lock_init;
      frozen_q <= nv_frozen_init;
    end
    else if (ce && busy && cyc_done && !link.line_low)
    begin
      // an interrupted cycle commits nothing
      if (frz_pend_q)
        frozen_q <= 1'b1;
      else if (!frozen_q)
        lock_q <= lock_q | zmask_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (ce)
      cnt_q <= busy ? cnt_q + 1'b1 : '0;
  end

  // the lock address is kept across a repeated start for the status read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zmask_q    <= 4'h0;
      zvalid_q   <= 1'b0;
      frz_pend_q <= 1'b0;
      maddr_q    <= 7'h00;
    end
    else if (ce)
    begin
      if (link.stop && !busy)
        zvalid_q <= 1'b0;
      else if (bv && state_q == D_ZADDR)
      begin
        zmask_q  <= b_zone;
        zvalid_q <= zaddr_ok;
      end
      if (bv && state_q == D_CMD)
        frz_pend_q <= is_frz;
      if (bv && state_q == D_MADDR)
        maddr_q <= link.byte_data[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link answers and array write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ack_valid_q <= 1'b0;
      ack_q       <= 1'b0;
      rd_valid_q  <= 1'b0;
      rd_data_q   <= 8'h00;
      mem_wr_q    <= 1'b0;
      mem_data_q  <= 8'h00;
    end
    else if (ce)
    begin
      ack_valid_q <= bv && !link.start && !link.stop && state_q != D_IDLE && state_q != D_ZREAD
                     && state_q != D_ZARMED && state_q != D_FARMED;
      ack_q       <= ack_now;
      rd_valid_q  <= state_q == D_ZREAD && link.rd_req && !link.start && !link.stop;
      if (state_q == D_ZREAD && link.rd_req)
        rd_data_q <= zlocked ? ezl_pkg::RD_LOCKED_BYTE : ezl_pkg::RD_UNLOCK_BYTE;
      mem_wr_q    <= bv && state_q == D_MDATA && !mlocked && !link.start && !link.stop;
      if (bv && state_q == D_MDATA)
        mem_data_q <= link.byte_data;
    end
  end

  assign link.ack_valid = ack_valid_q;
  assign link.ack       = ack_q;
  assign link.rd_valid  = rd_valid_q;
  assign link.rd_data   = rd_data_q;
  assign nv_lock        = lock_q;
  assign nv_frozen      = frozen_q;
  assign nv_busy        = busy;
  assign mem_wr         = mem_wr_q;
  assign mem_addr       = maddr_q;
  assign mem_data       = mem_data_q;

endmodule
`default_nettype wire

// file: hw/ezl_host.sv
// host controller: runs lock read, lock set, freeze and abort on the link
// assumes software drives it over apb; zero-wait-state slave
`timescale 1ns/1ns
`default_nettype none
module ezl_host #(
  parameter int unsigned WR_CYCLES  = ezl_pkg::NV_WRITE_CYCLES,
  parameter int unsigned DSCHG_CYCLES = ezl_pkg::LINE_DISCHARGE_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // link
  ezl_link_if.host         link
);

  typedef enum {H_IDLE, H_START, H_SEND, H_WACK, H_RSTART, H_RDREQ, H_WRD,
                H_STOP, H_WWR, H_DSCHG} ezl_hstate_e;

  ezl_hstate_e state_q;
  logic [1:0]  cmd_q;
  logic [1:0]  idx_q;
  logic [7:0]  b0_q, b1_q, b2_q;
  logic        done_q, nack_q;
  logic [7:0]  data_q;
  logic [31:0] prdata_q;
  logic [ezl_pkg::CNT_W-1:0] cnt_q;
  logic        start_q, stop_q, bvalid_q, rdreq_q, low_q;
  logic [7:0]  bdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire       setup    = psel && !penable;
  wire       wr_acc   = psel && penable && pwrite;
  wire       hit_ctrl = paddr == ezl_pkg::CTRL_OFFSET;
  wire       hit_st   = paddr == ezl_pkg::STATUS_OFFSET;
  wire [1:0] w_cmd    = pwdata[ezl_pkg::CTRL_CMD_LSB +: 2];
  wire [1:0] w_zone   = pwdata[ezl_pkg::CTRL_ZONE_LSB +: 2];
  wire [2:0] w_ca     = pwdata[ezl_pkg::CTRL_CA_LSB +: 3];
  wire       go       = wr_acc && hit_ctrl && pwdata[ezl_pkg::CTRL_GO_BIT];
  wire       abort    = go && w_cmd == ezl_pkg::CMD_ABORT && state_q == H_WWR;
  wire       launch   = go && w_cmd != ezl_pkg::CMD_ABORT && state_q == H_IDLE;
  wire [3:0] w_op     = w_cmd == ezl_pkg::CMD_FREEZE ? ezl_pkg::OP_FREEZE : ezl_pkg::OP_ZONE;
  wire [3:0] w_zaddr  = 4'h1 << w_zone;
  wire [7:0] w_b1     = w_cmd == ezl_pkg::CMD_FREEZE ? ezl_pkg::FRZ_ADDR_BYTE : {4'h0, w_zaddr};
  wire [7:0] w_b2     = w_cmd == ezl_pkg::CMD_FREEZE ? ezl_pkg::FRZ_DATA_BYTE
                      : w_cmd == ezl_pkg::CMD_SET ? ezl_pkg::LOCK_SET_BYTE : {w_op, w_ca, 1'b1};
  wire       is_read  = cmd_q == ezl_pkg::CMD_READ;
  wire [7:0] cur_b    = idx_q == 2'd0 ? b0_q : idx_q == 2'd1 ? b1_q : b2_q;
  wire       last_b   = idx_q == 2'd2;
  wire       busy     = state_q != H_IDLE;
  wire [31:0] status  = {16'h0000, data_q, 5'h00, nack_q, done_q, busy};
  wire       wr_end   = cnt_q == ezl_pkg::CNT_W'(WR_CYCLES - 1);
  wire       dsc_end  = cnt_q == ezl_pkg::CNT_W'(DSCHG_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // sequence
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= H_IDLE;
      cmd_q   <= 2'h0;
      idx_q   <= 2'd0;
      b0_q    <= 8'h00;
      b1_q    <= 8'h00;
      b2_q    <= 8'h00;
      done_q  <= 1'b0;
      nack_q  <= 1'b0;
      data_q  <= 8'h00;
      cnt_q   <= '0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_q + 1'b1;
      if (abort)
      begin
        state_q <= H_DSCHG;
        cnt_q   <= '0;
      end
      else
      begin
        case (state_q)
          H_IDLE:
            if (launch)
            begin
              state_q <= H_START;
              cmd_q   <= w_cmd;
              idx_q   <= 2'd0;
              b0_q    <= {w_op, w_ca, 1'b0};
              b1_q    <= w_b1;
              b2_q    <= w_b2;
              done_q  <= 1'b0;
              nack_q  <= 1'b0;
            end
          H_START:  state_q <= H_SEND;
          H_SEND:   state_q <= H_WACK;
          H_WACK:
            if (link.ack_valid && !link.ack)
            begin
              nack_q  <= 1'b1;
              state_q <= H_STOP;
            end
            else if (link.ack_valid && last_b)
              state_q <= is_read ? H_RDREQ : H_STOP;
            else if (link.ack_valid)
            begin
              idx_q   <= idx_q + 2'd1;
              state_q <= is_read && idx_q == 2'd1 ? H_RSTART : H_SEND;
            end
          H_RSTART: state_q <= H_SEND;
          H_RDREQ:  state_q <= H_WRD;
          H_WRD:
            if (link.rd_valid)
            begin
              data_q  <= link.rd_data;
              state_q <= H_STOP;
            end
          H_STOP:
          begin
            cnt_q   <= '0;
            state_q <= is_read || nack_q ? H_IDLE : H_WWR;
            done_q  <= is_read || nack_q;
          end
          H_WWR:
            if (wr_end)
            begin
              state_q <= H_IDLE;
              done_q  <= 1'b1;
            end
          H_DSCHG:
            if (dsc_end)
            begin
              state_q <= H_IDLE;
              done_q  <= 1'b1;
              nack_q  <= 1'b1;
            end
          default:  state_q <= H_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link drive, registered; line is left released while waiting the write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      start_q  <= 1'b0;
      stop_q   <= 1'b0;
      bvalid_q <= 1'b0;
      bdata_q  <= 8'h00;
      rdreq_q  <= 1'b0;
      low_q    <= 1'b0;
    end
    else if (ce)
    begin
      start_q  <= state_q == H_START || state_q == H_RSTART;
      stop_q   <= state_q == H_STOP;
      bvalid_q <= state_q == H_SEND;
      if (state_q == H_SEND)
        bdata_q <= cur_b;
      rdreq_q  <= state_q == H_RDREQ;
      low_q    <= (abort || state_q == H_DSCHG) && !(state_q == H_DSCHG && dsc_end);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (ce && setup)
      prdata_q <= hit_st ? status : 32'h0000_0000;
  end

  assign link.start      = start_q;
  assign link.stop       = stop_q;
  assign link.byte_valid = bvalid_q;
  assign link.byte_data  = bdata_q;
  assign link.rd_req     = rdreq_q;
  assign link.line_low   = low_q;
  assign prdata          = prdata_q;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !hit_ctrl && !hit_st;

endmodule
`default_nettype wire

// file: hw/ezl_link_if.sv
// byte-level view of the single-wire link between host and zone-lock device
// assumes both ends share pclk; bit framing is outside this block
`timescale 1ns/1ns
`default_nettype none
interface ezl_link_if;
  // host to device
  logic       start;
  logic       stop;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       rd_req;
  logic       line_low;
  // device to host
  logic       ack_valid;
  logic       ack;
  logic       rd_valid;
  logic [7:0] rd_data;

  modport dev  (input start, stop, byte_valid, byte_data, rd_req, line_low,
                output ack_valid, ack, rd_valid, rd_data);
  modport host (output start, stop, byte_valid, byte_data, rd_req, line_low,
                input ack_valid, ack, rd_valid, rd_data);
endinterface
`default_nettype wire

// file: hw/ezl_pkg.sv
// constants shared by both ends of the zone-lock link and the host register map
// assumes a single 10 MHz clock on both ends
package ezl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command opcodes in the upper nibble of the device address byte
  localparam logic [3:0] OP_ZONE   = 4'h7;
  localparam logic [3:0] OP_FREEZE = 4'h1;
  localparam logic [3:0] OP_MEM    = 4'ha;

  // zone lock addresses, one-hot so the low nibble doubles as a zone mask
  localparam logic [3:0] ZONE0_LOCK_ADDR = 4'h1;
  localparam logic [3:0] ZONE1_LOCK_ADDR = 4'h2;
  localparam logic [3:0] ZONE2_LOCK_ADDR = 4'h4;
  localparam logic [3:0] ZONE3_LOCK_ADDR = 4'h8;
  localparam int unsigned ZONES          = 4;
  localparam int unsigned ZONE_SIZE_BITS = 256;
  localparam int unsigned ZONE_SEL_MSB   = 6;
  localparam int unsigned ZONE_SEL_LSB   = 5;

  // fixed data bytes
  localparam logic [7:0] LOCK_SET_BYTE   = 8'hff;
  localparam logic [7:0] FRZ_ADDR_BYTE   = 8'h55;
  localparam logic [7:0] FRZ_DATA_BYTE   = 8'haa;
  localparam logic [7:0] RD_LOCKED_BYTE  = 8'hff;
  localparam logic [7:0] RD_UNLOCK_BYTE  = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS            = 100;
  localparam int unsigned NV_WRITE_CYCLE_TIME_MS   = 5;
  localparam int unsigned NV_WRITE_CYCLES          = NV_WRITE_CYCLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned LINE_DISCHARGE_TIME_US   = 150;
  localparam int unsigned LINE_DISCHARGE_CYCLES    = (LINE_DISCHARGE_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                                     / CLK_PERIOD_NS;
  localparam int unsigned CNT_W                    = 20;

  ////////////////////////////////////////////////////////////////////////////
  // host register map (apb, byte addresses)
  localparam logic [11:0] CTRL_OFFSET   = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  // ctrl fields
  localparam int unsigned CTRL_CMD_LSB  = 0;
  localparam int unsigned CTRL_ZONE_LSB = 2;
  localparam int unsigned CTRL_GO_BIT   = 4;
  localparam int unsigned CTRL_CA_LSB   = 5;
  // status fields
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_DONE_BIT   = 1;
  localparam int unsigned ST_NACK_BIT   = 2;
  localparam int unsigned ST_DATA_LSB   = 8;

  // host commands
  localparam logic [1:0] CMD_READ   = 2'h0;
  localparam logic [1:0] CMD_SET    = 2'h1;
  localparam logic [1:0] CMD_FREEZE = 2'h2;
  localparam logic [1:0] CMD_ABORT  = 2'h3;

endpackage

// file: verif/eeprom_zone_lock_control_tb_top.sv
// self-checking bench: apb drives the host, which talks to the device over the link
// assumes a 10 MHz pclk and shortened write and discharge counts
`timescale 1ns/1ns
`default_nettype none
`define EZL_CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin mismatches++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end
module eeprom_zone_lock_control_tb_top;
  localparam int unsigned WR = 20;
  localparam int unsigned DS = 5;
  typedef struct packed {logic [1:0] cmd; logic [1:0] zone; logic [2:0] ca; logic nack; logic [7:0] data;} ezl_row_s;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  nv_cells = 4'h0;
  logic        nv_frz = 1'b0;
  logic [3:0]  nv_lock;
  logic        nv_frozen;
  logic        nv_busy;
  logic        ce = 1'b1;
  int          mismatches = 0;
  int          num_checks = 0;

  always #50 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////
  ezl_link_if u_ezl_link_if ();
  ezl_host #(.WR_CYCLES(WR), .DSCHG_CYCLES(DS)) u_ezl_host (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(u_ezl_link_if.host));
  ezl_device #(.WR_CYCLES(WR)) u_ezl_device (.pclk(pclk), .presetn(presetn), .ce(ce),
    .link(u_ezl_link_if.dev), .client_addr(3'h5), .nv_lock_init(nv_cells), .nv_frozen_init(nv_frz),
    .nv_lock(nv_lock), .nv_frozen(nv_frozen), .nv_busy(nv_busy), .mem_wr(), .mem_addr(), .mem_data());
  ezl_link_sva #(.DSCHG_CYCLES(DS)) u_ezl_link_sva (.pclk(pclk), .presetn(presetn),
    .start(u_ezl_link_if.start), .stop(u_ezl_link_if.stop), .byte_valid(u_ezl_link_if.byte_valid),
    .byte_data(u_ezl_link_if.byte_data), .rd_req(u_ezl_link_if.rd_req), .line_low(u_ezl_link_if.line_low),
    .ack_valid(u_ezl_link_if.ack_valid), .ack(u_ezl_link_if.ack), .rd_valid(u_ezl_link_if.rd_valid),
    .rd_data(u_ezl_link_if.rd_data));

  ////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // polls status until busy drops; a hung host ends the wait with busy still set
  task automatic launch(input ezl_row_s r, output logic [31:0] q);
    logic e;
    int   n;
    apb(1'b1, ezl_pkg::CTRL_OFFSET, {24'h0, r.ca, 1'b1, r.zone, r.cmd}, q, e);
    n = 0;
    q = 32'h1;
    while (q[ezl_pkg::ST_BUSY_BIT] !== 1'b0 && n++ < 500)
      apb(1'b0, ezl_pkg::STATUS_OFFSET, 32'h0, q, e);
  endtask

  task automatic do_row(input ezl_row_s r);
    logic [31:0] q;
    launch(r, q);
    `EZL_CHK("busy", 1'b0, q[ezl_pkg::ST_BUSY_BIT])
    `EZL_CHK("done", 1'b1, q[ezl_pkg::ST_DONE_BIT])
    `EZL_CHK("nack", r.nack, q[ezl_pkg::ST_NACK_BIT])
    if (!r.nack && r.cmd == ezl_pkg::CMD_READ)
      `EZL_CHK("lock byte", r.data, q[15:8])
    $display("test cmd %h zone %h done", r.cmd, r.zone);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  ezl_row_s rows [6] = '{
    '{ezl_pkg::CMD_READ, 2'h0, 3'h5, 1'b0, 8'h00},
    '{ezl_pkg::CMD_READ, 2'h3, 3'h5, 1'b0, 8'h00},
    '{ezl_pkg::CMD_SET,  2'h1, 3'h5, 1'b0, 8'h00},
    '{ezl_pkg::CMD_READ, 2'h1, 3'h5, 1'b0, 8'hff},
    '{ezl_pkg::CMD_READ, 2'h0, 3'h5, 1'b0, 8'h00},
    '{ezl_pkg::CMD_READ, 2'h2, 3'h3, 1'b1, 8'h00}};

  initial
  begin
    #(30000 * 100);
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    logic [31:0] q;
    logic        e;
    int          n;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    foreach (rows[i])
      do_row(rows[i]);
    // abort a lock write in flight: the bit must stay clear
    apb(1'b1, ezl_pkg::CTRL_OFFSET, {24'h0, 3'h5, 1'b1, 2'h3, ezl_pkg::CMD_SET}, q, e);
    n = 0;
    while (nv_busy !== 1'b1 && n++ < 100)
      @(posedge pclk);
    `EZL_CHK("write cycle", 1'b1, nv_busy)
    // a stalled clock enable must hold the write cycle where it stands
    ce <= 1'b0;
    repeat (WR + 5) @(posedge pclk);
    `EZL_CHK("held by ce", 1'b1, nv_busy)
    ce <= 1'b1;
    launch('{ezl_pkg::CMD_ABORT, 2'h0, 3'h5, 1'b0, 8'h00}, q);
    `EZL_CHK("abort failed", 1'b1, q[ezl_pkg::ST_NACK_BIT])
    $display("test abort done");
    do_row('{ezl_pkg::CMD_READ, 2'h3, 3'h5, 1'b0, 8'h00});
    do_row('{ezl_pkg::CMD_SET, 2'h2, 3'h5, 1'b0, 8'h00});
    do_row('{ezl_pkg::CMD_FREEZE, 2'h0, 3'h5, 1'b0, 8'h00});
    do_row('{ezl_pkg::CMD_FREEZE, 2'h0, 3'h5, 1'b1, 8'h00});
    do_row('{ezl_pkg::CMD_SET, 2'h3, 3'h5, 1'b1, 8'h00});
    do_row('{ezl_pkg::CMD_READ, 2'h3, 3'h5, 1'b0, 8'h00});
    `EZL_CHK("lock image", 4'h6, nv_lock)
    `EZL_CHK("frozen", 1'b1, nv_frozen)
    // reset with the nv cells keeping what the device wrote
    nv_cells <= nv_lock;
    nv_frz <= nv_frozen;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    `EZL_CHK("lock in reset", 4'h0, nv_lock)
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `EZL_CHK("lock after reset", 4'h6, nv_lock)
    apb(1'b0, ezl_pkg::STATUS_OFFSET, 32'h0, q, e);
    `EZL_CHK("status reset", 32'h0, q)
    apb(1'b0, 12'h008, 32'h0, q, e);
    `EZL_CHK("unmapped err", 1'b1, e)
    $display("test reset done");
    do_row('{ezl_pkg::CMD_READ, 2'h1, 3'h5, 1'b0, 8'hff});
    do_row('{ezl_pkg::CMD_FREEZE, 2'h0, 3'h5, 1'b1, 8'h00});
    tally_and_finish();
  end
endmodule
`default_nettype wire

// file: verif/ezl_link_sva.sv
// assertions on the byte-level link between the zone-lock host and device
// assumes one clock domain; instantiated beside the interface in the bench top
`timescale 1ns/1ns
`default_nettype none
module ezl_link_sva #(
  parameter int unsigned DSCHG_CYCLES = 5
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // host to device
  input wire logic       start,
  input wire logic       stop,
  input wire logic       byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic       rd_req,
  input wire logic       line_low,
  // device to host
  input wire logic       ack_valid,
  input wire logic       ack,
  input wire logic       rd_valid,
  input wire logic [7:0] rd_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // low_run_q counts how long the line has been held low; frz_q marks a sent freeze data byte
  logic [7:0] low_run_q;
  logic       frz_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      low_run_q <= 8'h00;
      frz_q     <= 1'b0;
    end
    else
    begin
      low_run_q <= line_low ? low_run_q + 8'h01 : 8'h00;
      frz_q     <= (byte_valid && byte_data == 8'haa) ? 1'b1 : (start ? 1'b0 : frz_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ack_after_byte: assert property (byte_valid && !line_low |=> ack_valid)
    else $error("byte not answered one cycle later");
  a_ack_needs_byte: assert property (ack_valid |-> $past(byte_valid))
    else $error("answer without a byte");
  a_ack_one_pulse: assert property (ack_valid |=> !ack_valid)
    else $error("answer longer than one cycle");
  a_read_answer: assert property (rd_req |=> rd_valid ##1 !rd_valid)
    else $error("read request not answered in one cycle");
  a_read_needs_req: assert property (rd_valid |-> $past(rd_req))
    else $error("read byte without request");
  a_read_code_only: assert property (rd_valid |-> (rd_data == 8'h00 || rd_data == 8'hff))
    else $error("lock read byte neither 00 nor ff");
  a_stop_no_answer: assert property (stop |=> !ack_valid && !rd_valid)
    else $error("answer right after stop");
  a_discharge_len: assert property ($fell(line_low) |-> low_run_q >= DSCHG_CYCLES)
    else $error("line low shorter than discharge time");
  a_freeze_released: assert property (stop && frz_q |=> !line_low [*8])
    else $error("line pulled low during freeze write");

  c_read_locked: cover property (rd_valid && rd_data == 8'hff);
  c_nack_seen: cover property (ack_valid && !ack);
  c_discharge: cover property ($fell(line_low));
  c_freeze_stop: cover property (stop && frz_q);
endmodule
`default_nettype wire
